// ==== inc/dpct_regs.svh ====
`ifndef DPCT_REGS_SVH
`define DPCT_REGS_SVH

// Register indices; byte address on the bus is four times the index
`define DPCT_IDX_CTRL 16'hF700
`define DPCT_IDX_IOCTL 16'hF701
`define DPCT_IDX_FLAGS 16'hF703
`define DPCT_IDX_IRQEN 16'hF704
`define DPCT_IDX_COUNT 16'hF706
`define DPCT_IDX_PERIOD 16'hF708
`define DPCT_IDX_PHASE 16'hF70A
`define DPCT_IDX_RUN 16'hF720
`define DPCT_IDX_SYNC 16'hF721
`define DPCT_IDX_PWM 16'hF722
`define DPCT_IDX_FUNC 16'hF723
`define DPCT_IDX_OUTEN 16'hF724
`define DPCT_IDX_INIT 16'hF725

// Control register fields
`define DPCT_CKS_LSB 0
`define DPCT_CKEG_LSB 3
`define DPCT_CCLR_LSB 5
// I/O control fields
`define DPCT_IOA_LSB 0
`define DPCT_IOB_LSB 4
// Function control: output level inversion
`define DPCT_FUNC_INV_BIT 4

// Reset values
`define DPCT_RST_BYTE 8'h00
`define DPCT_RST_COUNT 16'h0000
`define DPCT_RST_COMPARE 16'hFFFF
`define DPCT_RST_OUTEN 8'h03

// Compare codes that make a pin toggle
`define DPCT_TOGGLE_A 3'h1
`define DPCT_TOGGLE_B 3'h3

`endif

// ==== inc/dpct_pkg.sv ====
package dpct_pkg;

    typedef enum logic [2:0] {
        CLR_NONE = 3'b000,
        CLR_ON_PERIOD = 3'b001,
        CLR_ON_PHASE = 3'b010
    } clear_sel_t;

    typedef enum logic [2:0] {
        CKS_DIV1 = 3'b000,
        CKS_DIV2 = 3'b001,
        CKS_DIV4 = 3'b010,
        CKS_DIV8 = 3'b011,
        CKS_DIV32 = 3'b100,
        CKS_DIV8192 = 3'b101,
        CKS_EXT_A = 3'b110,
        CKS_EXT_B = 3'b111
    } clock_sel_t;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH_A = 2'b10,
        EDGE_BOTH_B = 2'b11
    } edge_sel_t;

endpackage

// ==== hw/compare_pin.sv ====
`timescale 1ns/1ps
`include "dpct_regs.svh"

module compare_pin #(
    parameter int CNT_W = 16,
    parameter logic [2:0] TOGGLE_CODE = 3'h1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic [CNT_W-1:0] compare_i,
    input wire logic [2:0] io_code_i,
    input wire logic pwm_i,
    input wire logic period_match_i,
    input wire logic init_load_i,
    input wire logic init_val_i,
    input wire logic flag_clr_i,
    output logic match_o,
    output logic level_o,
    output logic flag_o
);

    logic level_reg;
    logic flag_reg;

    // Compare is sampled on each count step, so a stopped counter does not refire
    assign match_o = tick_i && (count_i == compare_i);

    // Pin level: initial value until the first match, then the chosen action
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_reg <= 1'b0;
        end else if (init_load_i) begin
            level_reg <= init_val_i;
        end else if (pwm_i) begin
            if (period_match_i) begin
                level_reg <= 1'b1;
            end else if (match_o) begin
                level_reg <= 1'b0;
            end
        end else if (match_o) begin
            if (io_code_i == TOGGLE_CODE) begin
                level_reg <= ~level_reg;
            end else if (io_code_i == 3'h2) begin
                level_reg <= 1'b1;
            end else if (io_code_i != 3'h0 && !io_code_i[2]) begin
                level_reg <= 1'b0;
            end
        end
    end

    // Match flag; a match in the clearing cycle keeps the flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else if (match_o) begin
            flag_reg <= 1'b1;
        end else if (flag_clr_i) begin
            flag_reg <= 1'b0;
        end
    end

    assign level_o = level_reg;
    assign flag_o = flag_reg;

endmodule

// ==== hw/dual_phase_compare_timer.sv ====
`timescale 1ns/1ps
`include "dpct_regs.svh"

module dual_phase_compare_timer #(
    parameter int CNT_W = 16,
    parameter int PSC_W = 13,
    parameter int ADR_W = 18
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ext_clk_i,
    output logic pulse_out_a_o,
    output logic pulse_out_a_oe_n_o,
    output logic pulse_out_b_o,
    output logic pulse_out_b_oe_n_o,
    output logic irq_o
);

    // Software visible registers
    logic [7:0] timer_channel_control_reg;
    logic [7:0] compare_io_control_a_reg;
    logic [1:0] timer_irq_enable_register_reg;
    logic [CNT_W-1:0] channel_counter_reg;
    logic [CNT_W-1:0] channel_counter_next;
    logic [CNT_W-1:0] period_compare_reg;
    logic [CNT_W-1:0] phase_compare_reg;
    logic [1:0] counter_run_register_reg;
    logic sync_mode_register_reg;
    logic [1:0] pwm_select_register_reg;
    logic [7:0] function_control_register_reg;
    logic [1:0] output_master_enable_reg;
    logic [1:0] initial_output_control_reg;

    // Bus and internal state
    logic ack_reg;
    logic [31:0] dat_o_reg;
    logic [31:0] rd_data;
    logic [PSC_W-1:0] system_prescaler_reg;
    logic [1:0] flag_seen_reg;
    logic ext_s1_reg;
    logic ext_s2_reg;
    logic ext_s3_reg;
    logic ext_lvl_reg;
    logic ext_lvl_d_reg;
    logic pin_a_reg;
    logic pin_b_reg;
    logic oe_a_n_reg;
    logic oe_b_n_reg;
    logic irq_reg;

    logic req;
    logic wr_en;
    logic [15:0] idx;
    logic int_tick;
    logic ext_tick;
    logic tick;
    logic run;
    logic match_flag_a;
    logic match_flag_b;
    logic match_a;
    logic match_b;
    logic level_a;
    logic level_b;
    logic [1:0] flag_clr;
    logic init_load;
    logic counter_wr;
    dpct_pkg::clock_sel_t count_clock_select;
    dpct_pkg::edge_sel_t count_edge_select;
    dpct_pkg::clear_sel_t counter_clear_select;
    logic [2:0] io_control_field_a;
    logic [2:0] io_control_field_b;

    // Decode: a request is taken once, the write lands on the edge that sees ack
    assign req = cyc_i && stb_i && !ack_reg;
    assign wr_en = cyc_i && stb_i && we_i && ack_reg;
    assign idx = adr_i[ADR_W-1:2];

    assign count_clock_select = dpct_pkg::clock_sel_t'(timer_channel_control_reg[2:0]);
    assign count_edge_select = dpct_pkg::edge_sel_t'(timer_channel_control_reg[4:3]);
    assign counter_clear_select = dpct_pkg::clear_sel_t'(timer_channel_control_reg[7:5]);
    assign io_control_field_a = compare_io_control_a_reg[`DPCT_IOA_LSB +: 3];
    assign io_control_field_b = compare_io_control_a_reg[`DPCT_IOB_LSB +: 3];

    // Single cycle answer; unmapped addresses are acked and read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Read data is captured when the request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o_reg <= 32'h00000000;
        end else if (req) begin
            dat_o_reg <= rd_data;
        end
    end

    // Read multiplexer, narrow registers sit in the low bits
    always_comb begin
        rd_data = 32'h00000000;
        case (idx)
            `DPCT_IDX_CTRL: rd_data[7:0] = timer_channel_control_reg;
            `DPCT_IDX_IOCTL: rd_data[7:0] = compare_io_control_a_reg;
            `DPCT_IDX_FLAGS: rd_data[1:0] = {match_flag_b, match_flag_a};
            `DPCT_IDX_IRQEN: rd_data[1:0] = timer_irq_enable_register_reg;
            `DPCT_IDX_COUNT: rd_data[CNT_W-1:0] = channel_counter_reg;
            `DPCT_IDX_PERIOD: rd_data[CNT_W-1:0] = period_compare_reg;
            `DPCT_IDX_PHASE: rd_data[CNT_W-1:0] = phase_compare_reg;
            `DPCT_IDX_RUN: rd_data[1:0] = counter_run_register_reg;
            `DPCT_IDX_SYNC: rd_data[0] = sync_mode_register_reg;
            `DPCT_IDX_PWM: rd_data[1:0] = pwm_select_register_reg;
            `DPCT_IDX_FUNC: rd_data[7:0] = function_control_register_reg;
            `DPCT_IDX_OUTEN: rd_data[1:0] = output_master_enable_reg;
            `DPCT_IDX_INIT: rd_data[1:0] = initial_output_control_reg;
            default: rd_data = 32'h00000000;
        endcase
    end

    // Configuration registers up to a byte wide, lane 0 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_channel_control_reg <= `DPCT_RST_BYTE;
            compare_io_control_a_reg <= `DPCT_RST_BYTE;
            timer_irq_enable_register_reg <= 2'h0;
            function_control_register_reg <= `DPCT_RST_BYTE;
        end else if (wr_en && sel_i[0]) begin
            case (idx)
                `DPCT_IDX_CTRL: timer_channel_control_reg <= dat_i[7:0];
                `DPCT_IDX_IOCTL: compare_io_control_a_reg <= {1'b0, dat_i[6:0]};
                `DPCT_IDX_IRQEN: timer_irq_enable_register_reg <= dat_i[1:0];
                `DPCT_IDX_FUNC: function_control_register_reg <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Run, mode and pin control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_run_register_reg <= 2'h0;
            sync_mode_register_reg <= 1'b0;
            pwm_select_register_reg <= 2'h0;
            output_master_enable_reg <= 2'(`DPCT_RST_OUTEN);
            initial_output_control_reg <= 2'h0;
        end else if (wr_en && sel_i[0]) begin
            case (idx)
                `DPCT_IDX_RUN: counter_run_register_reg <= dat_i[1:0];
                `DPCT_IDX_SYNC: sync_mode_register_reg <= dat_i[0];
                `DPCT_IDX_PWM: pwm_select_register_reg <= dat_i[1:0];
                `DPCT_IDX_OUTEN: output_master_enable_reg <= dat_i[1:0];
                `DPCT_IDX_INIT: initial_output_control_reg <= dat_i[1:0];
                default: ;
            endcase
        end
    end

    // Compare registers, two byte lanes each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_compare_reg <= `DPCT_RST_COMPARE;
            phase_compare_reg <= `DPCT_RST_COMPARE;
        end else if (wr_en) begin
            if (idx == `DPCT_IDX_PERIOD) begin
                if (sel_i[0]) period_compare_reg[7:0] <= dat_i[7:0];
                if (sel_i[1]) period_compare_reg[15:8] <= dat_i[15:8];
            end
            if (idx == `DPCT_IDX_PHASE) begin
                if (sel_i[0]) phase_compare_reg[7:0] <= dat_i[7:0];
                if (sel_i[1]) phase_compare_reg[15:8] <= dat_i[15:8];
            end
        end
    end

    // Free running prescaler feeds every divided internal count rate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_prescaler_reg <= '0;
        end else begin
            system_prescaler_reg <= system_prescaler_reg + 1'b1;
        end
    end

    // External count clock: three stages, a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            ext_lvl_reg <= 1'b0;
            ext_lvl_d_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (ext_s2_reg == ext_s3_reg) begin
                ext_lvl_reg <= ext_s3_reg;
            end
            ext_lvl_d_reg <= ext_lvl_reg;
        end
    end

    // Edge choice applies to the external clock; internal rates count rising edges
    always_comb begin
        case (count_edge_select)
            dpct_pkg::EDGE_RISE: ext_tick = ext_lvl_reg && !ext_lvl_d_reg;
            dpct_pkg::EDGE_FALL: ext_tick = !ext_lvl_reg && ext_lvl_d_reg;
            default: ext_tick = ext_lvl_reg != ext_lvl_d_reg;
        endcase
    end

    // Prescaled tick: one pulse per wrap of the chosen low prescaler bits
    always_comb begin
        case (count_clock_select)
            dpct_pkg::CKS_DIV1: int_tick = 1'b1;
            dpct_pkg::CKS_DIV2: int_tick = system_prescaler_reg[0];
            dpct_pkg::CKS_DIV4: int_tick = &system_prescaler_reg[1:0];
            dpct_pkg::CKS_DIV8: int_tick = &system_prescaler_reg[2:0];
            dpct_pkg::CKS_DIV32: int_tick = &system_prescaler_reg[4:0];
            dpct_pkg::CKS_DIV8192: int_tick = &system_prescaler_reg;
            default: int_tick = 1'b0;
        endcase
    end

    // In synchronous mode the second channel's start bit also starts this one
    assign run = counter_run_register_reg[0] ||
                 (sync_mode_register_reg && counter_run_register_reg[1]);
    assign tick = run && (count_clock_select[2:1] == 2'b11 ? ext_tick : int_tick);

    // Next count: a bus write wins over counting, a clear match over increment
    assign counter_wr = wr_en && (idx == `DPCT_IDX_COUNT);
    always_comb begin
        channel_counter_next = channel_counter_reg;
        if (counter_wr) begin
            if (sel_i[0]) channel_counter_next[7:0] = dat_i[7:0];
            if (sel_i[1]) channel_counter_next[15:8] = dat_i[15:8];
        end else if (tick) begin
            if (counter_clear_select == dpct_pkg::CLR_ON_PERIOD && match_a) begin
                channel_counter_next = '0;
            end else if (counter_clear_select == dpct_pkg::CLR_ON_PHASE && match_b) begin
                channel_counter_next = '0;
            end else begin
                channel_counter_next = channel_counter_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_counter_reg <= `DPCT_RST_COUNT;
        end else begin
            channel_counter_reg <= channel_counter_next;
        end
    end

    // Flag clear needs a prior read showing the flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_seen_reg <= 2'h0;
        end else if (wr_en && idx == `DPCT_IDX_FLAGS && sel_i[0]) begin
            flag_seen_reg <= 2'h0;
        end else if (req && !we_i && idx == `DPCT_IDX_FLAGS) begin
            flag_seen_reg <= flag_seen_reg | {match_flag_b, match_flag_a};
        end
    end

    assign flag_clr = (wr_en && idx == `DPCT_IDX_FLAGS && sel_i[0]) ?
                      (flag_seen_reg & ~dat_i[1:0]) : 2'h0;
    assign init_load = wr_en && idx == `DPCT_IDX_INIT && sel_i[0];

    // Period channel drives pin A
    compare_pin #(
        .CNT_W(CNT_W),
        .TOGGLE_CODE(`DPCT_TOGGLE_A)
    ) u_period_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .count_i(channel_counter_reg),
        .compare_i(period_compare_reg),
        .io_code_i(io_control_field_a),
        .pwm_i(pwm_select_register_reg[0]),
        .period_match_i(1'b0),
        .init_load_i(init_load),
        .init_val_i(dat_i[0]),
        .flag_clr_i(flag_clr[0]),
        .match_o(match_a),
        .level_o(level_a),
        .flag_o(match_flag_a)
    );

    // Phase channel drives pin B; in PWM mode the period match sets it
    compare_pin #(
        .CNT_W(CNT_W),
        .TOGGLE_CODE(`DPCT_TOGGLE_B)
    ) u_phase_pin (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick),
        .count_i(channel_counter_reg),
        .compare_i(phase_compare_reg),
        .io_code_i(io_control_field_b),
        .pwm_i(pwm_select_register_reg[1]),
        .period_match_i(match_a),
        .init_load_i(init_load),
        .init_val_i(dat_i[1]),
        .flag_clr_i(flag_clr[1]),
        .match_o(match_b),
        .level_o(level_b),
        .flag_o(match_flag_b)
    );

    // Pin stage registered; a disabled output releases the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_a_reg <= 1'b0;
            pin_b_reg <= 1'b0;
            oe_a_n_reg <= 1'b1;
            oe_b_n_reg <= 1'b1;
        end else begin
            pin_a_reg <= level_a ^ function_control_register_reg[`DPCT_FUNC_INV_BIT];
            pin_b_reg <= level_b ^ function_control_register_reg[`DPCT_FUNC_INV_BIT];
            oe_a_n_reg <= output_master_enable_reg[0];
            oe_b_n_reg <= output_master_enable_reg[1];
        end
    end

    // Interrupt request is a level while any enabled flag stands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (match_flag_a && timer_irq_enable_register_reg[0]) ||
                       (match_flag_b && timer_irq_enable_register_reg[1]);
        end
    end

    assign dat_o = dat_o_reg;
    assign ack_o = ack_reg;
    assign pulse_out_a_o = pin_a_reg;
    assign pulse_out_a_oe_n_o = oe_a_n_reg;
    assign pulse_out_b_o = pin_b_reg;
    assign pulse_out_b_oe_n_o = oe_b_n_reg;
    assign irq_o = irq_reg;

endmodule

// ==== bench/dpct_monitor.sv ====
`timescale 1ns/1ps
`include "dpct_regs.svh"

module dpct_monitor #(
    parameter int ADR_W = 18
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic pulse_out_a_o,
    input wire logic pulse_out_a_oe_n_o,
    input wire logic pulse_out_b_o,
    input wire logic pulse_out_b_oe_n_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic take_w;
    logic inv_reg;
    logic [1:0] exp_reg;
    logic [15:0] idx;

    // A write is taken on the edge where the request is up and ack is not
    assign take_w = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign idx = adr_i[ADR_W-1:2];

    // Track pin inversion so an init load predicts the pin levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inv_reg <= 1'b0;
            exp_reg <= 2'h0;
        end else if (take_w && idx == `DPCT_IDX_FUNC) begin
            inv_reg <= dat_i[`DPCT_FUNC_INV_BIT];
        end else if (take_w && idx == `DPCT_IDX_INIT) begin
            exp_reg <= dat_i[1:0] ^ {2{inv_reg}};
        end
    end

    ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acked next cycle");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    oe_rst_a: assert property ($fell(rst_i)
        |-> pulse_out_a_oe_n_o && pulse_out_b_oe_n_o && !irq_o)
        else $error("outputs not idle after reset");
    oe_on_a: assert property (take_w && idx == `DPCT_IDX_OUTEN && !dat_i[0]
        |-> ##[2:4] !pulse_out_a_oe_n_o)
        else $error("pin a not driven after enable");
    oe_off_a: assert property (take_w && idx == `DPCT_IDX_OUTEN && dat_i[1]
        |-> ##[2:4] pulse_out_b_oe_n_o)
        else $error("pin b still driven after disable");
    init_load_a: assert property (take_w && idx == `DPCT_IDX_INIT
        |-> ##[2:4] {pulse_out_b_o, pulse_out_a_o} == exp_reg)
        else $error("init level not on pins");
    irq_mask_a: assert property (take_w && idx == `DPCT_IDX_IRQEN
        && dat_i[1:0] == 2'h0 |-> ##[2:4] !irq_o)
        else $error("irq with both enables off");
    unmapped_read_a: assert property (cyc_i && stb_i && !we_i && !ack_o && idx == 16'hF702
        |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

// ==== bench/pulse_sink.sv ====
`timescale 1ns/1ps

module pulse_sink (
    input wire logic clk_i,
    input wire logic level_a_i,
    input wire logic oe_n_a_i,
    input wire logic level_b_i,
    input wire logic oe_n_b_i,
    output logic wire_a_o,
    output logic wire_b_o,
    output int a_gap_o,
    output int b_gap_o,
    output int b_to_a_o
);
    int now;
    int last_a;
    int last_b;
    logic prev_a;
    logic prev_b;

    // The lines carry pull-downs, so an undriven pin reads low
    assign wire_a_o = oe_n_a_i ? 1'b0 : level_a_i;
    assign wire_b_o = oe_n_b_i ? 1'b0 : level_b_i;

    // Time every edge in system clocks; equal gaps mean 50% duty
    always @(posedge clk_i) begin
        now <= now + 1;
        prev_a <= wire_a_o;
        prev_b <= wire_b_o;
        if (wire_a_o !== prev_a) begin
            a_gap_o <= now - last_a;
            b_to_a_o <= now - last_b;
            last_a <= now;
        end
        if (wire_b_o !== prev_b) begin
            b_gap_o <= now - last_b;
            last_b <= now;
        end
    end
endmodule

// ==== bench/dual_phase_compare_timer_test.sv ====
`timescale 1ns/1ps
`include "dpct_regs.svh"

module dual_phase_compare_timer_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [17:0] adr_i = 18'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic ext_clk_i = 1'b0;
    logic [31:0] dat_o, rd, held;
    logic ack_o, pa, pa_oe_n, pb, pb_oe_n, irq_o, wire_a, wire_b;
    int error_cnt = 0;
    int cmp_count = 0;
    int ticks = 0;
    int a_gap, b_gap, b_to_a;
    logic [15:0] ridx [14] = '{`DPCT_IDX_CTRL, `DPCT_IDX_IOCTL, `DPCT_IDX_FLAGS,
        `DPCT_IDX_IRQEN, `DPCT_IDX_COUNT, `DPCT_IDX_PERIOD, `DPCT_IDX_PHASE, `DPCT_IDX_RUN,
        `DPCT_IDX_SYNC, `DPCT_IDX_PWM, `DPCT_IDX_FUNC, `DPCT_IDX_OUTEN, `DPCT_IDX_INIT, 16'hF702};
    logic [15:0] rexp [14] = '{16'h00, 16'h00, 16'h00, 16'h00, 16'h0000, 16'hFFFF, 16'hFFFF,
        16'h00, 16'h00, 16'h00, 16'h00, 16'h03, 16'h00, 16'h00};

    always #2.5 clk_i = ~clk_i;

    dual_phase_compare_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .ext_clk_i(ext_clk_i), .pulse_out_a_o(pa), .pulse_out_a_oe_n_o(pa_oe_n),
        .pulse_out_b_o(pb), .pulse_out_b_oe_n_o(pb_oe_n), .irq_o(irq_o));

    pulse_sink sink (.clk_i(clk_i), .level_a_i(pa), .oe_n_a_i(pa_oe_n), .level_b_i(pb),
        .oe_n_b_i(pb_oe_n), .wire_a_o(wire_a), .wire_b_o(wire_b), .a_gap_o(a_gap),
        .b_gap_o(b_gap), .b_to_a_o(b_to_a));

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic xfer(input logic [15:0] idx, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'h3;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        rd = dat_o;
        check(n, 32'd2, "ack latency");
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic [31:0] m);
        xfer(idx, 1'b0, 32'h0);
        check(rd & m, exp, "read");
    endtask

    // A hang ends the run through the same report
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({30'h0, pa_oe_n, pb_oe_n}, 32'h3, "oe idle");
        check({30'h0, wire_a, wire_b}, 32'h0, "wire idle");
        for (int i = 0; i < 14; i++) begin
            rdchk(ridx[i], {16'h0, rexp[i]}, (i >= 4 && i <= 6) ? 32'hFFFF : 32'hFF);
        end
        xfer(`DPCT_IDX_OUTEN, 1'b1, 32'h0);
        repeat (4) @(posedge clk_i);
        check({30'h0, pa_oe_n, pb_oe_n}, 32'h0, "oe on");
        xfer(`DPCT_IDX_INIT, 1'b1, 32'h3);
        repeat (4) @(posedge clk_i);
        check({30'h0, wire_a, wire_b}, 32'h3, "init high");
        xfer(`DPCT_IDX_FUNC, 1'b1, 32'h10);
        repeat (4) @(posedge clk_i);
        check({30'h0, wire_a, wire_b}, 32'h0, "inverted");
        xfer(`DPCT_IDX_FUNC, 1'b1, 32'h0);
        xfer(`DPCT_IDX_INIT, 1'b1, 32'h0);
        // Clear on period, rising edge, system clock halved; both pins toggle
        xfer(`DPCT_IDX_CTRL, 1'b1, 32'h21);
        xfer(`DPCT_IDX_IOCTL, 1'b1, 32'h31);
        xfer(`DPCT_IDX_PERIOD, 1'b1, 32'h9);
        xfer(`DPCT_IDX_PHASE, 1'b1, 32'h3);
        xfer(`DPCT_IDX_COUNT, 1'b1, 32'h0);
        xfer(`DPCT_IDX_IRQEN, 1'b1, 32'h3);
        repeat (4) @(posedge clk_i);
        check({30'h0, wire_a, wire_b}, 32'h0, "init before run");
        xfer(`DPCT_IDX_RUN, 1'b1, 32'h1);
        repeat (200) @(posedge clk_i);
        check(a_gap, 32'd20, "a half period");
        check(b_gap, 32'd20, "b half period");
        check(b_to_a, 32'd12, "phase delay");
        check({31'h0, irq_o}, 32'h1, "irq");
        // Quarter rate: every gap doubles
        xfer(`DPCT_IDX_CTRL, 1'b1, 32'h22);
        repeat (300) @(posedge clk_i);
        check(a_gap, 32'd40, "a quarter");
        check(b_to_a, 32'd24, "delay quarter");
        xfer(`DPCT_IDX_RUN, 1'b1, 32'h0);
        xfer(`DPCT_IDX_COUNT, 1'b0, 32'h0);
        held = rd & 32'hFFFF;
        check({31'h0, held <= 32'h9}, 32'h1, "count range");
        repeat (10) @(posedge clk_i);
        rdchk(`DPCT_IDX_COUNT, held, 32'hFFFF);
        xfer(`DPCT_IDX_COUNT, 1'b1, 32'h5);
        rdchk(`DPCT_IDX_COUNT, 32'h5, 32'hFFFF);
        rdchk(`DPCT_IDX_FLAGS, 32'h3, 32'h3);
        xfer(`DPCT_IDX_IRQEN, 1'b1, 32'h0);
        repeat (4) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0, "irq masked");
        xfer(`DPCT_IDX_IRQEN, 1'b1, 32'h1);
        repeat (4) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1, "irq a");
        rdchk(`DPCT_IDX_FLAGS, 32'h3, 32'h3);
        xfer(`DPCT_IDX_FLAGS, 1'b1, 32'h2);
        rdchk(`DPCT_IDX_FLAGS, 32'h2, 32'h3);
        repeat (4) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0, "irq cleared");
        // Pin B released reads low through its pull-down; pin A still drives
        xfer(`DPCT_IDX_INIT, 1'b1, 32'h3);
        xfer(`DPCT_IDX_OUTEN, 1'b1, 32'h2);
        repeat (4) @(posedge clk_i);
        check({28'h0, pa_oe_n, pb_oe_n, wire_a, wire_b}, 32'h6, "b released");
        // Channel one start bit alone moves nothing until sync mode ties it in
        xfer(`DPCT_IDX_RUN, 1'b1, 32'h2);
        repeat (20) @(posedge clk_i);
        rdchk(`DPCT_IDX_COUNT, 32'h5, 32'hFFFF);
        xfer(`DPCT_IDX_SYNC, 1'b1, 32'h1);
        repeat (20) @(posedge clk_i);
        xfer(`DPCT_IDX_COUNT, 1'b0, 32'h0);
        check({31'h0, (rd & 32'hFFFF) != 32'h5}, 32'h1, "sync run");
        // External clock, rising edges only: three pulses count three
        xfer(`DPCT_IDX_RUN, 1'b1, 32'h0);
        xfer(`DPCT_IDX_COUNT, 1'b1, 32'h0);
        xfer(`DPCT_IDX_CTRL, 1'b1, 32'h6);
        xfer(`DPCT_IDX_RUN, 1'b1, 32'h1);
        repeat (3) begin
            ext_clk_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_clk_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        repeat (4) @(posedge clk_i);
        rdchk(`DPCT_IDX_COUNT, 32'h3, 32'hFFFF);
        wrap_up();
    end
endmodule

bind dual_phase_compare_timer dpct_monitor #(.ADR_W(ADR_W)) mon (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pulse_out_a_o(pulse_out_a_o),
    .pulse_out_a_oe_n_o(pulse_out_a_oe_n_o), .pulse_out_b_o(pulse_out_b_o),
    .pulse_out_b_oe_n_o(pulse_out_b_oe_n_o), .irq_o(irq_o));
